// >>> dma_pair.sv
// Purpose: Read/write DMA channel pair with shared FIFO and register file
// Assumes: Memory controller and host interface share clk_sys_i
// Notes: One memory beat is in flight at a time
`timescale 1ns/1ps
// How it works
// - Read channel fills FIFO, write channel drains
// - Cyclic read reloads start after base size
// - Completion bits 0 and 1 per channel
// - Base size ignored for simple buffers
// - Burst width code gives burst read/write
// - 16-bit beats, held address, FIFO flush
// - Peripheral mode waits for host read request
// - Internal mode starts beats without request
// - Runs alone once both channels activated
// - Bursts of 32 bytes, split on plain banks
// - Count zero with irq bit and mask bit raises interrupt
module dma_pair
  import dma_pair_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
)
(
  input wire logic clk_sys_i, // System clock, 250 MHz
  input wire logic rst_n_i, // Sync reset, active low
  input wire logic ce_i, // Clock enable, freezes all state
  input wire logic [REG_AW-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [REG_AW-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic host_rd_req_i, // Host interface has receive data
  input wire logic mem_burst_ok_i, // Addressed bank takes bursts
  input wire logic mem_ack_i, // Memory beat finished
  input wire logic [31:0] mem_rdata_i, // Read beat data
  output logic mem_req_o, // Beat request, held until ack
  output logic mem_we_o, // Beat is a write
  output logic [31:0] mem_addr_o, // Beat address
  output logic [31:0] mem_wdata_o, // Write beat data
  output logic [2:0] mem_bytes_o, // Beat size in bytes
  output logic mem_burst_o, // Beat belongs to a burst
  output logic mem_blast_o, // Last beat of a burst
  output logic irq_o // Interrupt request, level
);
  chan_if ch[2] ();
  logic [31:0] daddr_q [2], daddr_d [2], dcnt_q [2], dcnt_d [2];
  logic [31:0] dbs_q [2], dbs_d [2], dattr_q [2], dattr_d [2];
  logic [31:0] dctl_q [2], dctl_d [2];
  logic [1:0] st_q, st_d, pend_q, pend_d, mask_q, mask_d, ld_q, ld_d;
  logic [1:0] act_w, done_w, beat_w;
  logic irq_d;
  logic aw_h_q, aw_h_d, w_h_q, w_h_d, bv_d, awr_d, wr_d;
  logic [REG_AW-1:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_d;
  logic [3:0] ws_q, ws_d;
  logic [1:0] br_d, rr_d;
  logic arr_d, rv_d, wr_fire;
  mem_state_t ms_q, ms_d;
  logic own_q, own_d, lock_q, lock_d, req_d, we_d, bur_d, bl_d;
  logic [31:0] ma_d, mw_d;
  logic [2:0] mb_d;
  logic rd_ok, wr_ok, sel_wr, push, pop, flush, f_in_rdy, f_out_vld;
  logic [31:0] f_head;

  // Registers byte-merge under the write strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (s[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  // Unmapped or unaligned addresses answer SLVERR
  function automatic logic mapped(input logic [REG_AW-1:0] a);
    logic ok;
    ok = 1'b0;
    if (a[1:0] == 2'h0)
    begin
      if (a < OFS_STATUS)
        ok = ({3'h0, a[4:0]} <= OFS_CTRL);
      else
        ok = (a == OFS_STATUS) || (a == OFS_IRQ_PEND)
          || (a == OFS_IRQ_MASK);
    end
    return ok;
  endfunction

  // Per-channel wiring to the two engines
  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    assign ch[i].load = ld_q[i];
    assign ch[i].addr = daddr_q[i];
    assign ch[i].count = dcnt_q[i];
    assign ch[i].bsize = dbs_q[i];
    assign ch[i].attr = dattr_q[i];
    assign ch[i].beat_ok = beat_w[i];
    assign act_w[i] = ch[i].active;
    assign done_w[i] = ch[i].done;
    dma_chan u_chan (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .c(ch[i])
    );
  end

  // Shared FIFO; flush drops leftovers when the write side closes
  dma_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .flush_i(flush),
    .in_valid_i(push),
    .in_ready_o(f_in_rdy),
    .in_data_i(mem_rdata_i),
    .out_valid_o(f_out_vld),
    .out_ready_i(pop),
    .out_data_o(f_head)
  );

  // AXI4-Lite handshakes; address and data may come in either order
  always_comb
  begin
    aw_h_d = aw_h_q;
    awa_d = awa_q;
    w_h_d = w_h_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bv_d = s_axi_bvalid;
    br_d = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_h_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_h_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      bv_d = 1'b0;
    wr_fire = aw_h_q && w_h_q && !s_axi_bvalid;
    if (wr_fire)
    begin
      aw_h_d = 1'b0;
      w_h_d = 1'b0;
      bv_d = 1'b1;
      br_d = mapped(awa_q) ? RESP_OKAY : RESP_SLVERR;
    end
    awr_d = !aw_h_d;
    wr_d = !w_h_d;
    rv_d = s_axi_rvalid;
    rd_d = s_axi_rdata;
    rr_d = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready)
      rv_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rv_d = 1'b1;
      rr_d = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rd_d = RST_WORD;
      if (s_axi_araddr < OFS_STATUS)
      begin
        unique case ({3'h0, s_axi_araddr[4:0]})
          OFS_ADDR: rd_d = daddr_q[s_axi_araddr[CH_SEL_BIT]];
          OFS_COUNT: rd_d = dcnt_q[s_axi_araddr[CH_SEL_BIT]];
          OFS_BSIZE: rd_d = dbs_q[s_axi_araddr[CH_SEL_BIT]];
          OFS_ATTR: rd_d = dattr_q[s_axi_araddr[CH_SEL_BIT]];
          OFS_CTRL: rd_d = {act_w[s_axi_araddr[CH_SEL_BIT]],
            dctl_q[s_axi_araddr[CH_SEL_BIT]][30:0]};
          default: rd_d = RST_WORD;
        endcase
      end
      else if (s_axi_araddr == OFS_STATUS)
        rd_d = {30'h0, st_q};
      else if (s_axi_araddr == OFS_IRQ_PEND)
        rd_d = {30'h0, pend_q};
      else if (s_axi_araddr == OFS_IRQ_MASK)
        rd_d = {30'h0, mask_q};
    end
    arr_d = !rv_d;
  end

  // Register file; a hardware set wins over a same-cycle clear
  always_comb
  begin
    daddr_d = daddr_q;
    dcnt_d = dcnt_q;
    dbs_d = dbs_q;
    dattr_d = dattr_q;
    dctl_d = dctl_q;
    st_d = st_q;
    pend_d = pend_q;
    mask_d = mask_q;
    ld_d = 2'h0;
    if (wr_fire && mapped(awa_q))
    begin
      if (awa_q < OFS_STATUS)
      begin
        unique case ({3'h0, awa_q[4:0]})
          OFS_ADDR: daddr_d[awa_q[CH_SEL_BIT]] =
            merge(daddr_q[awa_q[CH_SEL_BIT]], wd_q, ws_q);
          OFS_COUNT: dcnt_d[awa_q[CH_SEL_BIT]] =
            merge(dcnt_q[awa_q[CH_SEL_BIT]], wd_q, ws_q);
          OFS_BSIZE: dbs_d[awa_q[CH_SEL_BIT]] =
            merge(dbs_q[awa_q[CH_SEL_BIT]], wd_q, ws_q);
          OFS_ATTR: dattr_d[awa_q[CH_SEL_BIT]] =
            merge(dattr_q[awa_q[CH_SEL_BIT]], wd_q, ws_q);
          default:
          begin
            dctl_d[awa_q[CH_SEL_BIT]] =
              merge(dctl_q[awa_q[CH_SEL_BIT]], wd_q, ws_q);
            // Activation starts the channel and reopens its status bit
            if (dctl_d[awa_q[CH_SEL_BIT]][CTRL_ACT_BIT]
              && !act_w[awa_q[CH_SEL_BIT]])
            begin
              ld_d[awa_q[CH_SEL_BIT]] = 1'b1;
              st_d[awa_q[CH_SEL_BIT]] = 1'b0;
            end
          end
        endcase
      end
      else if (awa_q == OFS_STATUS && ws_q[0])
        st_d = st_q & ~wd_q[1:0];
      else if (awa_q == OFS_IRQ_PEND && ws_q[0])
        pend_d = pend_q & ~wd_q[1:0];
      else if (awa_q == OFS_IRQ_MASK && ws_q[0])
        mask_d = wd_q[1:0];
    end
    for (int i = 0; i < 2; i++)
      if (done_w[i])
      begin
        st_d[i] = 1'b1;
        if (dattr_q[i][ATTR_IRQ_BIT])
          pend_d[i] = 1'b1;
      end
    irq_d = |(pend_d & mask_d);
  end

  // Memory beats; write side first so the FIFO keeps moving
  always_comb
  begin
    // Peripheral mode waits for the host interface; internal does not
    rd_ok = act_w[CH_RD] && f_in_rdy
      && (dctl_q[CH_RD][CTRL_INT_BIT] || host_rd_req_i);
    wr_ok = act_w[CH_WR] && f_out_vld;
    // An open read burst keeps the bus unless it cannot go on
    sel_wr = wr_ok && !(lock_q && !own_q && rd_ok);
    ms_d = ms_q;
    own_d = own_q;
    lock_d = lock_q;
    req_d = mem_req_o;
    we_d = mem_we_o;
    ma_d = mem_addr_o;
    mw_d = mem_wdata_o;
    mb_d = mem_bytes_o;
    bur_d = mem_burst_o;
    bl_d = mem_blast_o;
    push = 1'b0;
    pop = 1'b0;
    beat_w = 2'h0;
    unique case (ms_q)
      MEM_IDLE:
        if (sel_wr || rd_ok)
        begin
          own_d = sel_wr;
          req_d = 1'b1;
          we_d = sel_wr;
          ma_d = ch[CH_WR].cur;
          mb_d = ch[CH_WR].bytes;
          mw_d = f_head;
          bur_d = dattr_q[CH_WR][ATTR_WID_LSB +: 3] == WID_BURST;
          bl_d = ch[CH_WR].last;
          if (!sel_wr)
          begin
            ma_d = ch[CH_RD].cur;
            mb_d = ch[CH_RD].bytes;
            bur_d = dattr_q[CH_RD][ATTR_WID_LSB +: 3] == WID_BURST;
            bl_d = ch[CH_RD].last;
          end
          // Plain banks see single beats; the address still steps
          bur_d = bur_d && mem_burst_ok_i;
          ms_d = MEM_BUSY;
        end
      MEM_BUSY:
        if (mem_ack_i)
        begin
          req_d = 1'b0;
          push = !own_q;
          pop = own_q;
          beat_w[own_q] = 1'b1;
          lock_d = mem_burst_o && !mem_blast_o;
          ms_d = MEM_IDLE;
        end
    endcase
    flush = done_w[CH_WR] && dattr_q[CH_RD][ATTR_FLUSH_BIT];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < 2; i++)
      begin
        daddr_q[i] <= RST_WORD;
        dcnt_q[i] <= RST_WORD;
        dbs_q[i] <= RST_WORD;
        dattr_q[i] <= RST_WORD;
        dctl_q[i] <= RST_WORD;
      end
      {st_q, pend_q, mask_q, ld_q} <= '0;
      irq_o <= 1'b0;
      {aw_h_q, w_h_q, s_axi_bvalid, s_axi_rvalid} <= '0;
      {s_axi_awready, s_axi_wready, s_axi_arready} <= 3'h7;
      awa_q <= '0;
      wd_q <= RST_WORD;
      ws_q <= '0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= RST_WORD;
      ms_q <= MEM_IDLE;
      {own_q, lock_q, mem_req_o, mem_we_o} <= '0;
      {mem_burst_o, mem_blast_o} <= '0;
      mem_addr_o <= RST_WORD;
      mem_wdata_o <= RST_WORD;
      mem_bytes_o <= '0;
    end
    else if (ce_i)
    begin
      daddr_q <= daddr_d;
      dcnt_q <= dcnt_d;
      dbs_q <= dbs_d;
      dattr_q <= dattr_d;
      dctl_q <= dctl_d;
      {st_q, pend_q, mask_q, ld_q} <= {st_d, pend_d, mask_d, ld_d};
      irq_o <= irq_d;
      {aw_h_q, w_h_q, s_axi_bvalid, s_axi_rvalid} <=
        {aw_h_d, w_h_d, bv_d, rv_d};
      {s_axi_awready, s_axi_wready, s_axi_arready} <=
        {awr_d, wr_d, arr_d};
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      s_axi_bresp <= br_d;
      s_axi_rresp <= rr_d;
      s_axi_rdata <= rd_d;
      ms_q <= ms_d;
      {own_q, lock_q, mem_req_o, mem_we_o} <= {own_d, lock_d, req_d, we_d};
      {mem_burst_o, mem_blast_o} <= {bur_d, bl_d};
      mem_addr_o <= ma_d;
      mem_wdata_o <= mw_d;
      mem_bytes_o <= mb_d;
    end
  end
endmodule

// >>> dma_pair_pkg.sv
// Purpose: Shared constants and types for the paired DMA channel block
// Assumes: One system clock; register bus is AXI4-Lite with 32-bit data
// Notes: Channel 0 is the read side, channel 1 the write side of the pair
package dma_pair_pkg;
  localparam int DATA_W = 32;
  localparam int REG_AW = 8;
  // Register byte offsets, channel 1 sits one stride above channel 0
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_BSIZE = 8'h08;
  localparam logic [7:0] OFS_ATTR = 8'h0C;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h40;
  localparam logic [7:0] OFS_IRQ_PEND = 8'h44;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h48;
  localparam int CH_SEL_BIT = 5;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Attribute word fields
  localparam int ATTR_IRQ_BIT = 31;
  localparam int ATTR_CYC_BIT = 29;
  localparam int ATTR_NOINC_BIT = 27;
  localparam int ATTR_WID_LSB = 7;
  localparam int ATTR_FLUSH_BIT = 5;
  localparam logic [2:0] WID_8 = 3'h1;
  localparam logic [2:0] WID_16 = 3'h2;
  localparam logic [2:0] WID_32 = 3'h3;
  localparam logic [2:0] WID_BURST = 3'h4;
  // Channel control fields
  localparam int CTRL_ACT_BIT = 31;
  localparam int CTRL_INT_BIT = 6;
  // Bursts move at most 32 bytes, eight 4-byte beats
  localparam int BURST_BYTES = 32;
  localparam logic [2:0] BURST_LAST_BEAT = 3'(BURST_BYTES / 4 - 1);
  localparam int CH_RD = 0;
  localparam int CH_WR = 1;
  typedef enum {MEM_IDLE, MEM_BUSY} mem_state_t;
endpackage

// >>> chan_if.sv
// Purpose: Bundle between the register file and one channel engine
// Assumes: Driven and sampled on clk_sys_i
// Notes: load and beat_ok are one-cycle pulses
`timescale 1ns/1ps
interface chan_if;
  logic load;
  logic [31:0] addr;
  logic [31:0] count;
  logic [31:0] bsize;
  logic [31:0] attr;
  logic beat_ok;
  logic active;
  logic done;
  logic last;
  logic [2:0] bytes;
  logic [31:0] cur;
  modport ctl (output load, addr, count, bsize, attr, beat_ok,
    input active, done, last, bytes, cur);
  modport eng (input load, addr, count, bsize, attr, beat_ok,
    output active, done, last, bytes, cur);
endinterface

// >>> dma_fifo.sv
// Purpose: Shared FIFO between the read and the write channel
// Assumes: DEPTH is a power of two
// Notes: flush_i drops every entry held
`timescale 1ns/1ps
module dma_fifo
#(
  parameter int W = 32,
  parameter int DEPTH = 16
)
(
  input wire logic clk_sys_i, // System clock
  input wire logic rst_n_i, // Sync reset, active low
  input wire logic ce_i, // Clock enable
  input wire logic flush_i, // Drop all entries
  input wire logic in_valid_i, // Push request
  output logic in_ready_o, // Room for one entry
  input wire logic [W-1:0] in_data_i, // Pushed word
  output logic out_valid_o, // Entry available
  input wire logic out_ready_i, // Pop request
  output logic [W-1:0] out_data_o // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] n_q, n_d;
  logic push, pop;

  // Pointer and fill arithmetic
  always_comb
  begin
    in_ready_o = (n_q != (AW+1)'(DEPTH));
    out_valid_o = (n_q != '0);
    out_data_o = mem_q[rp_q];
    push = in_valid_i && in_ready_o;
    pop = out_ready_i && out_valid_o;
    wp_d = push ? wp_q + AW'(1) : wp_q;
    rp_d = pop ? rp_q + AW'(1) : rp_q;
    n_d = n_q + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_i)
    begin
      wp_d = '0;
      rp_d = '0;
      n_d = '0;
    end
  end

  // Storage has no reset; the fill count guards stale words
  always_ff @(posedge clk_sys_i)
  begin
    if (ce_i && push)
      mem_q[wp_q] <= in_data_i;
    if (!rst_n_i)
    begin
      wp_q <= '0;
      rp_q <= '0;
      n_q <= '0;
    end
    else if (ce_i)
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      n_q <= n_d;
    end
  end
endmodule

// >>> dma_chan.sv
// Purpose: One channel engine walking its descriptor beat by beat
// Assumes: beat_ok comes only while active
// Notes: Working copies are taken at load; later register writes wait
`timescale 1ns/1ps
module dma_chan
  import dma_pair_pkg::*;
(
  input wire logic clk_sys_i, // System clock
  input wire logic rst_n_i, // Sync reset, active low
  input wire logic ce_i, // Clock enable
  chan_if.eng c // Link to register file
);
  logic act_q, act_d, done_q, done_d;
  logic [31:0] addr_q, addr_d, start_q, start_d, cnt_q, cnt_d;
  logic [31:0] seg_q, seg_d, bsz_q, bsz_d, attr_q, attr_d;
  logic [2:0] bcnt_q, bcnt_d, wid, bytes;

  // Beat size, trimmed so the last beat never overruns the count
  always_comb
  begin
    unique case (attr_q[ATTR_WID_LSB +: 3])
      WID_8: wid = 3'h1;
      WID_16: wid = 3'h2;
      default: wid = 3'h4;
    endcase
    bytes = (cnt_q < {29'h0, wid}) ? cnt_q[2:0] : wid;
    c.bytes = bytes;
    c.cur = addr_q;
    c.active = act_q;
    c.done = done_q;
    c.last = (bcnt_q == BURST_LAST_BEAT) || (cnt_q <= {29'h0, bytes});
  end

  // Descriptor progress
  always_comb
  begin
    act_d = act_q;
    done_d = 1'b0;
    addr_d = addr_q;
    start_d = start_q;
    cnt_d = cnt_q;
    seg_d = seg_q;
    bsz_d = bsz_q;
    attr_d = attr_q;
    bcnt_d = bcnt_q;
    if (c.load)
    begin
      addr_d = c.addr;
      start_d = c.addr;
      cnt_d = c.count;
      bsz_d = c.bsize;
      attr_d = c.attr;
      seg_d = '0;
      bcnt_d = '0;
      act_d = (c.count != '0);
      done_d = (c.count == '0);
    end
    else if (c.beat_ok && act_q)
    begin
      cnt_d = cnt_q - {29'h0, bytes};
      bcnt_d = bcnt_q + 3'h1;
      if (!attr_q[ATTR_NOINC_BIT])
        addr_d = addr_q + {29'h0, bytes};
      seg_d = seg_q + {29'h0, bytes};
      // Base size only matters for a cyclic buffer
      if (attr_q[ATTR_CYC_BIT] && seg_d >= bsz_q)
      begin
        addr_d = start_q;
        seg_d = '0;
      end
      if (cnt_d == '0)
      begin
        act_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      act_q <= 1'b0;
      done_q <= 1'b0;
      addr_q <= RST_WORD;
      start_q <= RST_WORD;
      cnt_q <= RST_WORD;
      seg_q <= RST_WORD;
      bsz_q <= RST_WORD;
      attr_q <= RST_WORD;
      bcnt_q <= '0;
    end
    else if (ce_i)
    begin
      act_q <= act_d;
      done_q <= done_d;
      addr_q <= addr_d;
      start_q <= start_d;
      cnt_q <= cnt_d;
      seg_q <= seg_d;
      bsz_q <= bsz_d;
      attr_q <= attr_d;
      bcnt_q <= bcnt_d;
    end
  end
endmodule

// >>> dma_pair_mem_model.sv
// Purpose: Memory bank model answering dma_pair beats
// Assumes: One beat in flight, request held until acknowledged
// Notes: Read data is a fixed function of the beat address
`timescale 1ns/1ps
module dma_pair_mem_model
(
  input wire logic clk_sys_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic mem_req_i, // Beat request
  input wire logic [31:0] mem_addr_i, // Beat address
  input wire logic [1:0] dly_i, // Extra wait cycles
  output logic mem_ack_o, // Beat finished
  output logic [31:0] mem_rdata_o // Read data
);
  logic [1:0] wait_q;
  // One ack per request; the ack itself restarts the wait count
  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i || !mem_req_i || mem_ack_o)
    begin
      wait_q <= 2'h0;
      mem_ack_o <= 1'h0;
    end
    else
    begin
      wait_q <= wait_q + 2'h1;
      mem_ack_o <= (wait_q >= dly_i);
    end
  end
  // Outside an ack the lines show other data, so stale reads fail
  assign mem_rdata_o = mem_ack_o ? mem_addr_i ^ 32'h5A5A0000 : ~mem_addr_i;
endmodule

// >>> dma_pair_chk.sv
// Purpose: Port-level checks for dma_pair
// Assumes: ce_i held high throughout
// Notes: Attached by the bind at the foot of this file
`timescale 1ns/1ps
module dma_pair_chk
(
  input wire logic clk_sys_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic mem_req_o, // Beat request
  input wire logic mem_ack_i, // Beat finished
  input wire logic [31:0] mem_addr_o, // Beat address
  input wire logic [2:0] mem_bytes_o, // Beat size
  input wire logic mem_burst_o, // Burst beat
  input wire logic mem_burst_ok_i, // Bank takes bursts
  input wire logic irq_o // Interrupt
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // A beat must not move while the bank is still working on it
  chk_beat_hold: assert property (
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("beat changed before ack");
  chk_beat_release: assert property (
    mem_req_o && mem_ack_i |=> !mem_req_o)
    else $error("request held after ack");
  chk_burst_word: assert property (
    mem_req_o && mem_burst_o |-> mem_bytes_o == 3'h4)
    else $error("burst beat not a word");
  chk_burst_bank: assert property (
    $rose(mem_req_o) && mem_burst_o |-> $past(mem_burst_ok_i))
    else $error("burst issued to plain bank");
  chk_beat_size: assert property (
    mem_req_o |-> mem_bytes_o != 3'h0 && mem_bytes_o <= 3'h4)
    else $error("bad beat size");
  chk_resp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_reset_idle: assert property (
    $rose(rst_n_i) |-> !mem_req_o && !irq_o)
    else $error("busy out of reset");
  // Main scenarios reached
  cover property (mem_req_o && mem_burst_o && mem_ack_i);
  cover property (mem_req_o && mem_bytes_o == 3'h2 && mem_ack_i);
  cover property ($rose(irq_o));
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind dma_pair dma_pair_chk u_dma_pair_chk (.*);

// >>> dma_pair_test.sv
// Purpose: Self-checking bench for dma_pair
// Assumes: 250 MHz clock, registers over AXI4-Lite
// Notes: Expected results queue up; a monitor matches them
`timescale 1ns/1ps
module dma_pair_test;
  import dma_pair_pkg::*;
  logic clk_sys_i, rst_n_i = 1'h0, hen = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, seed = 32'hD44B4844, dmask = 32'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic host_rd_req_i = 1'h0, mem_burst_ok_i = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, mem_ack_i, mem_req_o, mem_we_o, mem_burst_o, irq_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, dly = 2'h0;
  logic [31:0] s_axi_rdata, mem_rdata_i, mem_addr_o, mem_wdata_o;
  logic [2:0] mem_bytes_o;
  logic [33:0] q[$];
  logic [63:0] mq[$];
  int n_mismatch = 0;
  int n_tests = 0;
  // Bench nets carry the port names, so most pins connect by name
  dma_pair u_dma_pair (.*, .ce_i(1'h1), .s_axi_wstrb(4'hF),
    .mem_blast_o());
  dma_pair_mem_model u_dma_pair_mem_model (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
    .dly_i(dly), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
  initial
  begin
    clk_sys_i = 1'h0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (q.size() != 0 || mq.size() != 0)
      n_mismatch++;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Address and data go up together; each is dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r = RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk_sys_i);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid && n < 200);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r = RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clk_sys_i);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid && n < 200);
    s_axi_rready <= 1'h0;
  endtask
  // Waits for all noted write beats, then lets status settle
  task automatic drain();
    int n;
    n = 0;
    while (mq.size() != 0 && n < 4000)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    repeat (6) @(posedge clk_sys_i);
  endtask
  // A result with no note against it is compared with unknown and fails
  always @(posedge clk_sys_i)
  begin
    if (s_axi_bvalid && s_axi_bready)
      cmp({s_axi_bresp, 32'h0}, q.size() != 0 ? q.pop_front() : 'x);
    if (s_axi_rvalid && s_axi_rready)
      cmp({s_axi_rresp, s_axi_rdata}, q.size() != 0 ? q.pop_front() : 'x);
    if (mem_req_o && mem_ack_i && mem_we_o)
      cmp({mem_addr_o, mem_wdata_o & dmask}, mq.size() != 0 ? mq.pop_front() : 'x);
    if (mem_req_o && mem_ack_i && !mem_we_o && dmask == 32'h0)
      cmp({mem_bytes_o, mem_addr_o}, {3'h2, 32'h3000});
  end
  // Random ack delay and bank type; host data only once enabled
  always @(posedge clk_sys_i)
  begin
    seed <= xs(seed);
    dly <= seed[1:0];
    mem_burst_ok_i <= seed[2];
    host_rd_req_i <= hen & seed[3];
  end
  initial
  begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    rd(OFS_STATUS, 32'h0);
    rd(CH_STRIDE + OFS_CTRL, 32'h0);
    wr(8'h4C, 32'h1, RESP_SLVERR);
    rd(8'h4C, 32'h0, RESP_SLVERR);
    $display("test reset done");
    // 32-byte cyclic burst source feeding a 64-byte burst write
    dmask = 32'hFFFFFFFF;
    wr(OFS_IRQ_MASK, 32'h3);
    wr(OFS_ADDR, 32'h1000);
    wr(OFS_COUNT, 32'h40);
    wr(OFS_BSIZE, 32'h20);
    wr(OFS_ATTR, 32'hE0400210);
    wr(CH_STRIDE + OFS_ADDR, 32'h2000);
    wr(CH_STRIDE + OFS_COUNT, 32'h40);
    wr(CH_STRIDE + OFS_BSIZE, 32'h8);
    wr(CH_STRIDE + OFS_ATTR, 32'h200);
    for (int i = 0; i < 16; i++)
      mq.push_back({32'h2000 + 32'(4 * i),
        (32'h1000 + 32'(4 * (i % 8))) ^ 32'h5A5A0000});
    wr(OFS_CTRL, 32'hC0000040);
    wr(CH_STRIDE + OFS_CTRL, 32'hC0010040);
    drain();
    cmp(irq_o, 1'h1);
    rd(OFS_STATUS, 32'h3);
    rd(OFS_IRQ_PEND, 32'h1);
    wr(OFS_IRQ_PEND, 32'h1);
    wr(OFS_STATUS, 32'h3);
    repeat (2) @(posedge clk_sys_i);
    cmp(irq_o, 1'h0);
    rd(OFS_STATUS, 32'h0);
    $display("test cyclic burst done");
    // Host-paced 16-bit reads from one held address
    dmask = 32'h0;
    wr(OFS_ADDR, 32'h3000);
    wr(OFS_COUNT, 32'h8);
    wr(OFS_ATTR, 32'h08000130);
    wr(CH_STRIDE + OFS_ADDR, 32'h4000);
    wr(CH_STRIDE + OFS_COUNT, 32'h8);
    wr(CH_STRIDE + OFS_ATTR, 32'h80000120);
    for (int i = 0; i < 4; i++)
      mq.push_back({32'h4000 + 32'(2 * i), 32'h0});
    wr(OFS_CTRL, 32'h81800005);
    wr(CH_STRIDE + OFS_CTRL, 32'hC0010040);
    repeat (20) @(posedge clk_sys_i);
    cmp(mem_req_o, 1'h0);
    rd(OFS_STATUS, 32'h0);
    hen <= 1'h1;
    drain();
    rd(OFS_STATUS, 32'h3);
    rd(OFS_IRQ_PEND, 32'h2);
    cmp(irq_o, 1'h1);
    wr(OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    cmp(irq_o, 1'h0);
    $display("test host paced done");
    print_verdict();
  end
endmodule
